// >>> design/lsmu_core.sv
// Summary of operation
// - Unprivileged access address is base register plus unsigned 0..255 immediate.
// - Unprivileged accesses always reach memory marked unprivileged.
// - Byte and halfword loads zero- or sign-extend to 32 bits.
// - No operation here ever writes the condition flags.
// - Relative loads use program counter plus signed offset.
// - Loaded program counter value must have bit 0 set; branch clears it.
// - Multiple transfers support increment-after (default) and decrement-before.
// - Increment-after walks upward by 4, lowest register at lowest address.
// - Decrement-before walks downward by 4, highest register at highest address.
// - Writeback stores final accessed address into the base register.
// - Stack alias names map onto increment-after or decrement-before.
// - Multiple transfers move whole 32-bit words only.
// - Push is decrement-before store, pop increment-after load, both with writeback.
// - Push stores in decreasing register order.
// - Pop loads in increasing register order.
`timescale 1ns/100ps
`default_nettype none
module lsmu_core #(
   parameter int OFFSET_W = 13
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Operation request
   input wire logic op_valid_i,
   output logic op_ready_o,
   input wire lsmu_pkg::lsmu_kind_t op_kind_i,
   input wire lsmu_pkg::lsmu_amode_t op_amode_i,
   input wire logic op_writeback_i,
   input wire logic op_unpriv_i,
   input wire logic op_pcrel_i,
   input wire logic [1:0] op_size_i,
   input wire logic op_signed_i,
   input wire logic [3:0] base_register_i,
   input wire logic [31:0] base_value_i,
   input wire logic [31:0] program_counter_i,
   input wire logic [OFFSET_W-1:0] offset_i,
   input wire logic [3:0] transfer_register_i,
   input wire logic [3:0] second_transfer_register_i,
   input wire logic [15:0] reg_list_i,
   input wire logic privileged_i,
   // Register file
   output logic [3:0] rd_idx_o,
   input wire logic [31:0] rd_data_i,
   output logic rf_we_o,
   output logic [3:0] rf_idx_o,
   output logic [31:0] rf_wdata_o,
   output logic flags_we_o,
   // Branch
   output logic branch_o,
   output logic [31:0] branch_target_o,
   // Memory
   output logic mem_req_o,
   output logic mem_write_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [1:0] mem_size_o,
   output logic mem_unpriv_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i
);
   if (OFFSET_W < 13 || OFFSET_W > 32) begin : g_chk
      $error("OFFSET_W must be 13..32");
   end

   lsmu_pkg::lsmu_state_t state_ff, nxt_state;
   logic list_ff, desc_ff, wb_ff, load_ff, dual_ff, phase_ff, sign_ff, unpriv_ff;
   logic [1:0] size_ff;
   logic [3:0] rt_ff, rt2_ff, base_ff;
   logic [15:0] mask_ff;
   logic [31:0] last_addr_ff;
   logic [3:0] lo_idx, hi_idx;

   lsmu_ext_if ext_bus ();
   lsmu_extend u_extend (.ext(ext_bus));
   assign ext_bus.raw = mem_rdata_i;
   assign ext_bus.size = size_ff;
   assign ext_bus.sign = sign_ff;

   // Request decode
   wire accept = op_valid_i & op_ready_o;
   wire is_push = op_kind_i == lsmu_pkg::KIND_PUSH;
   wire is_pop = op_kind_i == lsmu_pkg::KIND_POP;
   wire is_list = is_push | is_pop | op_kind_i == lsmu_pkg::KIND_LOAD_MULTIPLE
      | op_kind_i == lsmu_pkg::KIND_STORE_MULTIPLE;
   wire is_load = op_kind_i == lsmu_pkg::KIND_LOAD | op_kind_i == lsmu_pkg::KIND_LOAD_DUAL
      | op_kind_i == lsmu_pkg::KIND_LOAD_MULTIPLE | is_pop;
   wire is_dual = op_kind_i == lsmu_pkg::KIND_LOAD_DUAL;
   wire amode_db = op_amode_i == lsmu_pkg::AMODE_DECREMENT_BEFORE
      | (op_amode_i == lsmu_pkg::AMODE_EMPTY_ASCENDING & is_load)
      | (op_amode_i == lsmu_pkg::AMODE_FULL_DESCENDING & !is_load);
   // Single and dual accesses always step upward, whatever mode is left on the port
   wire new_desc = is_push | (amode_db & is_list & !is_pop);
   wire new_wb = is_push | is_pop | (is_list & op_writeback_i);
   wire [3:0] new_base = (is_push | is_pop) ? lsmu_pkg::REG_SP : base_register_i;
   wire [31:0] off_sext = 32'(signed'(offset_i));
   wire [31:0] imm_zext = {{(32 - lsmu_pkg::UNPRIV_IMM_W){1'b0}},
      offset_i[lsmu_pkg::UNPRIV_IMM_W-1:0]};
   wire use_pc = op_pcrel_i | is_dual;
   wire [31:0] single_addr = use_pc ? program_counter_i + off_sext
      : base_value_i + imm_zext;
   wire [31:0] list_addr = new_desc ? base_value_i - lsmu_pkg::WORD_BYTES
      : base_value_i;
   wire [31:0] start_addr = is_list ? list_addr : single_addr;

   // Lowest and highest remaining register of the list
   always_comb begin
      lo_idx = 4'h0;
      hi_idx = 4'h0;
      for (int i = lsmu_pkg::NUM_REGS - 1; i >= 0; i--) begin
         if (mask_ff[i]) begin
            lo_idx = 4'(i);
         end
      end
      for (int i = 0; i < lsmu_pkg::NUM_REGS; i++) begin
         if (mask_ff[i]) begin
            hi_idx = 4'(i);
         end
      end
   end

   wire [3:0] sel_idx = list_ff ? (desc_ff ? hi_idx : lo_idx)
      : (phase_ff ? rt2_ff : rt_ff);
   wire [15:0] mask_left = mask_ff & ~(16'h0001 << sel_idx);
   wire more = list_ff ? (mask_left != 16'h0000) : (dual_ff & !phase_ff);
   wire [31:0] step_addr = desc_ff ? mem_addr_o - lsmu_pkg::WORD_BYTES
      : mem_addr_o + lsmu_pkg::WORD_BYTES;
   wire done_ack = state_ff == lsmu_pkg::ST_ACCESS & mem_ack_i;
   wire load_ack = done_ack & load_ff;
   wire pc_load = load_ack & sel_idx == lsmu_pkg::REG_PC;
   // Bit 0 is dropped so the target is always halfword aligned
   wire [31:0] pc_target = {ext_bus.value[31:1], 1'b0};
   wire next_is_read = !load_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         lsmu_pkg::ST_IDLE: begin
            if (accept) begin
               nxt_state = is_load ? lsmu_pkg::ST_ACCESS : lsmu_pkg::ST_READ;
            end
         end
         lsmu_pkg::ST_READ: nxt_state = lsmu_pkg::ST_ACCESS;
         lsmu_pkg::ST_ACCESS: begin
            if (mem_ack_i) begin
               if (more) begin
                  nxt_state = next_is_read ? lsmu_pkg::ST_READ : lsmu_pkg::ST_ACCESS;
               end else begin
                  nxt_state = wb_ff ? lsmu_pkg::ST_WBACK : lsmu_pkg::ST_IDLE;
               end
            end
         end
         lsmu_pkg::ST_WBACK: nxt_state = lsmu_pkg::ST_IDLE;
         default: nxt_state = lsmu_pkg::ST_IDLE;
      endcase
   end

   wire nxt_ready = nxt_state == lsmu_pkg::ST_IDLE;
   wire nxt_req = nxt_state == lsmu_pkg::ST_ACCESS;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_ff <= lsmu_pkg::ST_IDLE;
         op_ready_o <= 1'b0;
         mem_req_o <= 1'b0;
         rf_we_o <= 1'b0;
         branch_o <= 1'b0;
         flags_we_o <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ready_o <= nxt_ready;
         mem_req_o <= nxt_req;
         rf_we_o <= (load_ack & !pc_load) | state_ff == lsmu_pkg::ST_WBACK;
         branch_o <= pc_load;
         flags_we_o <= 1'b0;
      end
   end

   // Datapath: no reset needed, qualified by the control flops above
   always_ff @(posedge ref_clk_i) begin
      if (accept) begin
         list_ff <= is_list;
         desc_ff <= new_desc;
         wb_ff <= new_wb;
         load_ff <= is_load;
         dual_ff <= is_dual;
         phase_ff <= 1'b0;
         sign_ff <= op_signed_i & is_load & !is_list;
         size_ff <= is_list ? lsmu_pkg::SIZE_WORD : op_size_i;
         unpriv_ff <= op_unpriv_i;
         rt_ff <= transfer_register_i;
         rt2_ff <= second_transfer_register_i;
         base_ff <= new_base;
         mask_ff <= reg_list_i;
         mem_addr_o <= start_addr;
      end else if (done_ack) begin
         mask_ff <= mask_left;
         phase_ff <= 1'b1;
         last_addr_ff <= mem_addr_o;
         mem_addr_o <= (list_ff | dual_ff) ? step_addr : mem_addr_o;
      end
      rd_idx_o <= (nxt_state == lsmu_pkg::ST_READ && state_ff != lsmu_pkg::ST_READ)
         ? (accept ? (is_list ? (new_desc ? rd_hi(reg_list_i) : rd_lo(reg_list_i))
            : transfer_register_i) : (list_ff ? (desc_ff ? rd_hi(mask_left)
            : rd_lo(mask_left)) : rt2_ff)) : rd_idx_o;
      if (state_ff == lsmu_pkg::ST_READ) begin
         mem_wdata_o <= rd_data_i;
      end
      mem_write_o <= nxt_req & !(accept ? is_load : load_ff);
      mem_size_o <= accept ? (is_list ? lsmu_pkg::SIZE_WORD : op_size_i) : size_ff;
      // Unprivileged forms are marked so regardless of current level
      mem_unpriv_o <= accept ? (op_unpriv_i | !privileged_i)
         : (unpriv_ff | !privileged_i);
      rf_idx_o <= state_ff == lsmu_pkg::ST_WBACK ? base_ff : sel_idx;
      rf_wdata_o <= state_ff == lsmu_pkg::ST_WBACK ? last_addr_ff : ext_bus.value;
      branch_target_o <= pc_load ? pc_target : branch_target_o;
   end

   function automatic logic [3:0] rd_lo(input logic [15:0] m);
      rd_lo = 4'h0;
      for (int i = lsmu_pkg::NUM_REGS - 1; i >= 0; i--) begin
         if (m[i]) begin
            rd_lo = 4'(i);
         end
      end
   endfunction : rd_lo

   function automatic logic [3:0] rd_hi(input logic [15:0] m);
      rd_hi = 4'h0;
      for (int i = 0; i < lsmu_pkg::NUM_REGS; i++) begin
         if (m[i]) begin
            rd_hi = 4'(i);
         end
      end
   endfunction : rd_hi

   // Checks
   wire chk_ia_step = done_ack & list_ff & !desc_ff & more & load_ff;
   wire chk_db_step = done_ack & list_ff & desc_ff & more & load_ff;
   wire chk_sbyte = load_ack & size_ff == lsmu_pkg::SIZE_BYTE & sign_ff & !pc_load;

   a_flags_untouched: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !flags_we_o) else $error("flags written");
   a_branch_aligned: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      branch_o |-> !branch_target_o[0] && !rf_we_o) else $error("branch target odd");
   a_unpriv_mark: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (mem_req_o && unpriv_ff) |-> mem_unpriv_o) else $error("unpriv not marked");
   a_unpriv_addr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (accept && !use_pc && !is_list) |=> mem_addr_o == $past(base_value_i)
      + {24'h000000, $past(offset_i[7:0])}) else $error("unpriv address wrong");
   a_pcrel_addr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (accept && use_pc && !is_list) |=> mem_addr_o == $past(program_counter_i)
      + 32'(signed'($past(offset_i)))) else $error("relative address wrong");
   a_ia_upward: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      chk_ia_step |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 32'h4)
      else $error("increment step wrong");
   a_db_downward: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      chk_db_step |=> mem_req_o && mem_addr_o == $past(mem_addr_o) - 32'h4)
      else $error("decrement step wrong");
   a_multi_word: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (mem_req_o && list_ff) |-> mem_size_o == lsmu_pkg::SIZE_WORD) else $error("not word");
   a_push_form: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (accept && is_push) |=> desc_ff && wb_ff && base_ff == lsmu_pkg::REG_SP
      && mem_addr_o == $past(base_value_i) - 32'h4) else $error("push form wrong");
   a_alias_decode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (accept && op_kind_i == lsmu_pkg::KIND_LOAD_MULTIPLE
      && op_amode_i == lsmu_pkg::AMODE_EMPTY_ASCENDING) |=> desc_ff) else $error("alias");
   a_sbyte_ext: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      chk_sbyte |=> rf_wdata_o[31:8] == {24{rf_wdata_o[7]}}) else $error("sign extension");
   a_wb_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_ff == lsmu_pkg::ST_WBACK) |=> rf_we_o && rf_idx_o == $past(base_ff)
      && rf_wdata_o == $past(last_addr_ff)) else $error("writeback wrong");
endmodule : lsmu_core
`default_nettype wire

// >>> design/lsmu_pkg.sv
package lsmu_pkg;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LR = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;
   localparam logic [31:0] WORD_BYTES = 32'h4;
   localparam int UNPRIV_IMM_W = 8;
   localparam int NUM_REGS = 16;
   localparam int BYTE_MSB = 7;
   localparam int HALF_MSB = 15;

   typedef enum logic [2:0] {
      KIND_LOAD = 3'h0,
      KIND_STORE = 3'h1,
      KIND_LOAD_DUAL = 3'h2,
      KIND_LOAD_MULTIPLE = 3'h3,
      KIND_STORE_MULTIPLE = 3'h4,
      KIND_PUSH = 3'h5,
      KIND_POP = 3'h6
   } lsmu_kind_t;

   // Addressing spelled as written, including the stack aliases
   typedef enum logic [1:0] {
      AMODE_INCREMENT_AFTER = 2'h0,
      AMODE_DECREMENT_BEFORE = 2'h1,
      AMODE_FULL_DESCENDING = 2'h2,
      AMODE_EMPTY_ASCENDING = 2'h3
   } lsmu_amode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_READ = 2'h1,
      ST_ACCESS = 2'h2,
      ST_WBACK = 2'h3
   } lsmu_state_t;
endpackage : lsmu_pkg

// >>> design/lsmu_ext_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lsmu_ext_if;
   logic [31:0] raw;
   logic [1:0] size;
   logic sign;
   logic [31:0] value;
   modport ctl (output raw, output size, output sign, input value);
   modport ext (input raw, input size, input sign, output value);
endinterface : lsmu_ext_if
`default_nettype wire

// >>> design/lsmu_extend.sv
`timescale 1ns/100ps
`default_nettype none
module lsmu_extend (
   lsmu_ext_if.ext ext
);
   wire byte_fill = ext.sign & ext.raw[lsmu_pkg::BYTE_MSB];
   wire half_fill = ext.sign & ext.raw[lsmu_pkg::HALF_MSB];

   always_comb begin
      case (ext.size)
         lsmu_pkg::SIZE_BYTE: ext.value = {{24{byte_fill}}, ext.raw[7:0]};
         lsmu_pkg::SIZE_HALF: ext.value = {{16{half_fill}}, ext.raw[15:0]};
         default: ext.value = ext.raw;
      endcase
   end
endmodule : lsmu_extend
`default_nettype wire

// >>> sim/lsmu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsmu_mem_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Core memory side
   input wire logic mem_req_i,
   input wire logic [31:0] mem_addr_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   logic [1:0] wait_ff;
   // Always odd, so any word may be loaded into the program counter
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return (a * 32'h9e3779b1) | 32'h1;
   endfunction : word_at
   // Data is scrambled outside the ack cycle so stale reads show up
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mem_ack_o <= 1'b0;
         mem_rdata_o <= 32'h0;
      end else if (!mem_req_i || mem_ack_o) begin
         mem_ack_o <= 1'b0;
         wait_ff <= 2'($urandom_range(2));
         mem_rdata_o <= ~mem_rdata_o;
      end else if (wait_ff != 2'h0) begin
         wait_ff <= wait_ff - 2'h1;
         mem_rdata_o <= ~mem_rdata_o;
      end else begin
         mem_ack_o <= 1'b1;
         mem_rdata_o <= word_at(mem_addr_i);
      end
   end
endmodule : lsmu_mem_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic op_valid_i = 1'b0, op_writeback_i = 1'b0, op_unpriv_i = 1'b0, op_pcrel_i = 1'b0;
   logic op_signed_i = 1'b0, privileged_i = 1'b0;
   lsmu_pkg::lsmu_kind_t op_kind_i = lsmu_pkg::KIND_LOAD;
   lsmu_pkg::lsmu_amode_t op_amode_i = lsmu_pkg::AMODE_INCREMENT_AFTER;
   logic [1:0] op_size_i = 2'h2;
   logic [3:0] base_register_i = 4'h0, transfer_register_i = 4'h0;
   logic [3:0] second_transfer_register_i = 4'h1;
   logic [31:0] base_value_i = 32'h0, program_counter_i = 32'h0;
   logic [12:0] offset_i = 13'h0;
   logic [15:0] reg_list_i = 16'h1;
   logic op_ready_o, rf_we_o, flags_we_o, branch_o, mem_req_o, mem_write_o, mem_unpriv_o;
   logic mem_ack_i;
   logic [1:0] mem_size_o;
   logic [3:0] rd_idx_o, rf_idx_o;
   logic [31:0] rd_data_i, rf_wdata_o, branch_target_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic [67:0] mem_q[$];
   logic [36:0] rw_q[$];
   int n_fail = 0, checks = 0, cyc = 0;
   logic ld, pc;

   lsmu_core lsmu_core_i (.ref_clk_i, .reset_i, .op_valid_i, .op_ready_o, .op_kind_i,
      .op_amode_i, .op_writeback_i, .op_unpriv_i, .op_pcrel_i, .op_size_i, .op_signed_i,
      .base_register_i, .base_value_i, .program_counter_i, .offset_i, .transfer_register_i,
      .second_transfer_register_i, .reg_list_i, .privileged_i, .rd_idx_o, .rd_data_i,
      .rf_we_o, .rf_idx_o, .rf_wdata_o, .flags_we_o, .branch_o, .branch_target_o, .mem_req_o,
      .mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_size_o, .mem_unpriv_o, .mem_ack_i,
      .mem_rdata_i);
   lsmu_mem_model lsmu_mem_model_i (.ref_clk_i, .reset_i, .mem_req_i(mem_req_o),
      .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

   function automatic logic [31:0] rfval(input logic [3:0] r);
      return {4{4'ha, r}};
   endfunction : rfval
   function automatic logic [31:0] ext(input logic [31:0] w, input logic [1:0] s, input logic g);
      if (s == lsmu_pkg::SIZE_BYTE) return {{24{g & w[7]}}, w[7:0]};
      if (s == lsmu_pkg::SIZE_HALF) return {{16{g & w[15]}}, w[15:0]};
      return w;
   endfunction : ext
   assign rd_data_i = rfval(rd_idx_o);

   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         give_verdict();
      end
      if (!reset_i) begin
         check("flags_we", 64'(flags_we_o), 64'h0);
         if (mem_req_o && mem_ack_i)
            mem_q.push_back({mem_wdata_o, mem_write_o, mem_unpriv_o, mem_size_o, mem_addr_o});
         if (rf_we_o) rw_q.push_back({1'b0, rf_idx_o, rf_wdata_o});
         if (branch_o) rw_q.push_back({1'b1, 4'hf, branch_target_o});
      end
   end

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // One op in flight; the extra edge lets the monitor log the last cycle
   task automatic issue();
      op_valid_i <= 1'b1;
      do @(posedge ref_clk_i); while (op_ready_o !== 1'b1);
      op_valid_i <= 1'b0;
      do @(posedge ref_clk_i); while (op_ready_o !== 1'b1);
      @(posedge ref_clk_i);
   endtask : issue
   task automatic see_mem(input logic [31:0] a, input logic w, u, input logic [1:0] s,
                          input logic [31:0] d);
      logic [67:0] e;
      e = mem_q.size() ? mem_q.pop_front() : 'x;
      check("mem_access", 64'(e[35:0]), 64'({w, u, s, a}));
      if (w) check("mem_wdata", 64'(e[67:36] & ext('1, s, 1'b0)),
         64'(d & ext('1, s, 1'b0)));
   endtask : see_mem
   task automatic exp_rf(input logic [3:0] r, input logic [31:0] v);
      logic [36:0] e;
      logic br;
      e = rw_q.size() ? rw_q.pop_front() : 'x;
      br = (r == lsmu_pkg::REG_PC);
      check("reg_write", 64'(e), 64'({br, r, br ? v & ~32'h1 : v}));
   endtask : exp_rf
   task automatic single(input lsmu_pkg::lsmu_kind_t k, input logic p, input logic [1:0] s,
                         input logic g, input logic [3:0] rt, input logic [12:0] off);
      logic [31:0] b, pcv, a;
      logic pv;
      b = $urandom;
      pcv = $urandom;
      pv = 1'($urandom);
      op_kind_i <= k;
      {op_pcrel_i, op_unpriv_i, op_size_i, op_signed_i} <= {p, !p, s, g};
      transfer_register_i <= rt;
      second_transfer_register_i <= rt ^ 4'h1;
      {base_value_i, program_counter_i, offset_i, privileged_i} <= {b, pcv, off, pv};
      issue();
      a = p ? pcv + 32'(signed'(off)) : b + {24'h0, off[7:0]};
      see_mem(a, k == lsmu_pkg::KIND_STORE, !p || !pv, s, rfval(rt));
      if (k == lsmu_pkg::KIND_LOAD_DUAL) begin
         see_mem(a + 32'h4, 1'b0, !pv, s, 32'h0);
         exp_rf(rt, lsmu_mem_model_i.word_at(a));
         exp_rf(rt ^ 4'h1, lsmu_mem_model_i.word_at(a + 32'h4));
      end else if (k == lsmu_pkg::KIND_LOAD) begin
         exp_rf(rt, ext(lsmu_mem_model_i.word_at(a), s, g));
      end
      check("leftover", 64'(mem_q.size() + rw_q.size()), 64'h0);
   endtask : single
   task automatic multi(input lsmu_pkg::lsmu_kind_t k, input lsmu_pkg::lsmu_amode_t m,
                        input logic wb);
      logic [15:0] l;
      logic [3:0] bi;
      logic [31:0] b, a;
      logic ld, db, stk, pv;
      int i, r;
      ld = k inside {lsmu_pkg::KIND_LOAD_MULTIPLE, lsmu_pkg::KIND_POP};
      stk = k inside {lsmu_pkg::KIND_PUSH, lsmu_pkg::KIND_POP};
      bi = stk ? lsmu_pkg::REG_SP : 4'($urandom_range(12));
      l = 16'($urandom) & ~(16'h1 << bi) & 16'hdfff;
      if (!ld) l[15] = 1'b0;
      if (l[15]) l[14] = 1'b0;
      if (l == 16'h0) l = (bi == 4'h0) ? 16'h0002 : 16'h0001;
      db = (k == lsmu_pkg::KIND_PUSH) || (!stk && (m == lsmu_pkg::AMODE_DECREMENT_BEFORE ||
         m == (ld ? lsmu_pkg::AMODE_EMPTY_ASCENDING : lsmu_pkg::AMODE_FULL_DESCENDING)));
      b = $urandom;
      pv = 1'($urandom);
      op_kind_i <= k;
      op_amode_i <= m;
      // Unprivileged flag of an earlier single op must not leak into lists
      op_unpriv_i <= 1'b0;
      {op_writeback_i, reg_list_i} <= {wb, l};
      {base_register_i, base_value_i, privileged_i} <= {bi, b, pv};
      issue();
      a = db ? b : b - 32'h4;
      for (i = 0; i < 16; i++) begin
         r = db ? 15 - i : i;
         if (l[r]) begin
            a = db ? a - 32'h4 : a + 32'h4;
            see_mem(a, !ld, !pv, lsmu_pkg::SIZE_WORD, rfval(4'(r)));
            if (ld) exp_rf(4'(r), lsmu_mem_model_i.word_at(a));
         end
      end
      if (wb || stk) exp_rf(bi, a);
      check("leftover", 64'(mem_q.size() + rw_q.size()), 64'h0);
   endtask : multi

   initial begin
      void'($urandom(32'hfacca3b2));
      repeat (12) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      single(lsmu_pkg::KIND_LOAD, 1'b1, lsmu_pkg::SIZE_WORD, 1'b0, lsmu_pkg::REG_PC,
         13'h1001);
      single(lsmu_pkg::KIND_LOAD, 1'b1, lsmu_pkg::SIZE_WORD, 1'b0, lsmu_pkg::REG_PC, 13'h0fff);
      single(lsmu_pkg::KIND_LOAD_DUAL, 1'b1, lsmu_pkg::SIZE_WORD, 1'b0, 4'h4, 13'h1c04);
      single(lsmu_pkg::KIND_LOAD_DUAL, 1'b1, lsmu_pkg::SIZE_WORD, 1'b0, 4'h4, 13'h03fc);
      single(lsmu_pkg::KIND_STORE, 1'b0, lsmu_pkg::SIZE_BYTE, 1'b0, 4'h2, 13'h0000);
      single(lsmu_pkg::KIND_LOAD, 1'b0, lsmu_pkg::SIZE_HALF, 1'b1, 4'h3, 13'h00ff);
      repeat (60) begin
         ld = 1'($urandom);
         pc = ld & 1'($urandom);
         single(ld ? lsmu_pkg::KIND_LOAD : lsmu_pkg::KIND_STORE, pc, 2'($urandom_range(2)),
            ld & 1'($urandom), 4'($urandom_range(12)), 13'($urandom_range(8190) - 4095));
      end
      for (int m = 0; m < 8; m++) begin
         repeat (6) multi(m[2] ? lsmu_pkg::KIND_STORE_MULTIPLE : lsmu_pkg::KIND_LOAD_MULTIPLE,
            lsmu_pkg::lsmu_amode_t'(m[1:0]), 1'($urandom));
      end
      repeat (10) multi(lsmu_pkg::KIND_PUSH, lsmu_pkg::AMODE_INCREMENT_AFTER, 1'b0);
      repeat (10) multi(lsmu_pkg::KIND_POP, lsmu_pkg::AMODE_DECREMENT_BEFORE, 1'b0);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
